// ==== dv/ebp_bus_model.sv ====
// Purpose: external bus controller and board pins around the block
// Assumes: controller on the system clock
// Notes: address counts every cycle so stale drive shows up
`timescale 1ns/1ps
module ebp_bus_model (
   input  wire logic        clk,           // system clock
   input  wire logic        reset,         // sync reset
   input  wire logic        bus_drive,     // controller owns muxed lines
   input  wire logic [7:0]  ext_high,      // board level, high pins
   input  wire logic [15:0] ext_low,       // board level, low pins
   input  wire logic [7:0]  high_pin_out,  // block drive
   input  wire logic [7:0]  high_pin_oe,   // block enable
   input  wire logic [15:0] low_pin_out,   // block drive
   input  wire logic [15:0] low_pin_oe,    // block enable
   output logic      [7:0]  high_pin_in,   // resolved pins
   output logic      [15:0] low_pin_in,    // resolved pins
   output logic      [7:0]  upper_addr,    // address lines 16 up
   output logic      [15:0] muxed_bus_out, // muxed line drive
   output logic      [15:0] muxed_bus_oe   // muxed line enable
);
   logic [15:0] cnt_reg;  // address sequence
   // ==========================================
   // address sequencer
   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_reg <= 16'h0000;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end
   // released lines carry the inverse, not a stale copy
   assign upper_addr = cnt_reg[7:0];
   assign muxed_bus_out = bus_drive ? cnt_reg : ~cnt_reg;
   assign muxed_bus_oe = {16{bus_drive}};
   // wire level: driver wins, board level otherwise
   assign high_pin_in = (high_pin_oe & high_pin_out) | (~high_pin_oe & ext_high);
   assign low_pin_in = (low_pin_oe & low_pin_out) | (~low_pin_oe & ext_low);
endmodule

// ==== dv/ebp_port_pins_checker.sv ====
// Purpose: port-level checks of the port pin block
// Assumes: one clock, sync reset, one wait state per apb transfer
// Notes: bound to every ebp_port_pins instance
`timescale 1ns/1ps
module ebp_port_pins_checker import ebp_pkg::*; (
   input wire logic        clk,          // system clock
   input wire logic        reset,        // sync reset
   input wire logic        psel,         // apb select
   input wire logic        penable,      // apb access
   input wire logic        pwrite,       // apb write
   input wire logic [31:0] paddr,        // apb address
   input wire logic        pready,       // apb ready
   input wire logic [31:0] prdata,       // apb read data
   input wire logic        pslverr,      // apb error
   input wire logic [15:0] low_pin_in,   // low pins
   input wire logic [15:0] low_pin_oe,   // low enables
   input wire logic [7:0]  high_pin_oe,  // high enables
   input wire logic [15:0] muxed_bus_in  // pins to bus
);
   // ==========================================
   // helpers
   logic [1:0]  age_reg;  // cycles since reset, saturating
   logic [11:0] idx;      // decoded index
   logic        mapped;   // index hits a register
   assign idx = paddr[13:2];
   assign mapped = idx inside {IDX_LOW_DATA[11:0], IDX_LOW_DATA_UPPER[11:0],
      IDX_HIGH_DATA[11:0], IDX_LOW_DIR[11:0], IDX_LOW_DIR_UPPER[11:0],
      IDX_HIGH_DIR[11:0], IDX_LOW_FS[11:0], IDX_LOW_FS_UPPER[11:0], IDX_HIGH_FS[11:0]};
   // sync chain holds reset zeros for three edges, so wait it out
   always_ff @(posedge clk) begin
      if (reset) begin
         age_reg <= 2'd0;
      end else if (age_reg != 2'd3) begin
         age_reg <= age_reg + 2'd1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // ==========================================
   // assertions
   property p_one_wait; psel && penable && !pready |=> pready; endproperty
   a_one_wait: assert property (p_one_wait) else $error("ready not after one wait");
   property p_ready_cause; pready |-> psel && penable && $past(psel && penable); endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
   property p_ready_pulse; pready |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
   property p_idle_data; !pready |-> prdata == 32'h0000_0000; endproperty
   a_idle_data: assert property (p_idle_data) else $error("read data outside ready");
   property p_err_ready; pslverr |-> pready; endproperty
   a_err_ready: assert property (p_err_ready) else $error("error without ready");
   property p_unmapped; pready && !mapped |-> pslverr && prdata == 32'h0000_0000; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
   property p_read_ok; pready && mapped && !pwrite |-> !pslverr; endproperty
   a_read_ok: assert property (p_read_ok) else $error("mapped read refused");
   property p_sync; age_reg == 2'd3 |-> muxed_bus_in == $past(low_pin_in, 3); endproperty
   a_sync: assert property (p_sync) else $error("bus input latency wrong");
   property p_reset; $past(reset) |-> !pready && low_pin_oe == 16'h0000 && high_pin_oe == 8'h00;
   endproperty
   a_reset: assert property (p_reset) else $error("pins driven after reset");
endmodule
bind ebp_port_pins ebp_port_pins_checker i_chk (.clk, .reset, .psel, .penable, .pwrite, .paddr,
   .pready, .prdata, .pslverr, .low_pin_in, .low_pin_oe, .high_pin_oe, .muxed_bus_in);

// ==== dv/external_bus_port_pins_test.sv ====
// Purpose: self-checking bench for the port pin block
// Assumes: apb master with NBA drive at rising edges
// Notes: pins checked at the falling edge after commit
`timescale 1ns/1ps
module external_bus_port_pins_test import ebp_pkg::*;;
   logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, bus_drive = 0;
   logic [31:0] paddr = 0, pwdata = 0, prdata, rd, prdata_s, rd_s;
   logic [3:0]  pstrb = 0;
   logic        pready, pslverr, er;
   logic [7:0]  high_pin_in, high_pin_out, high_pin_oe, upper_addr, ext_high = 0;
   logic [15:0] low_pin_in, low_pin_out, low_pin_oe, muxed_bus_out, muxed_bus_oe;
   logic [15:0] muxed_bus_in, ext_low = 0;
   int          mismatches = 0, n_compared = 0, cyc = 0;
   ebp_port_pins #(.SMALL_HIGH_PORT(1'b0)) i_dut (.clk, .reset, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .high_pin_in, .high_pin_out,
      .high_pin_oe, .low_pin_in, .low_pin_out, .low_pin_oe, .upper_addr, .muxed_bus_out,
      .muxed_bus_oe, .muxed_bus_in);
   // six-pin variant on the same bus, only its read data is watched
   ebp_port_pins #(.SMALL_HIGH_PORT(1'b1)) i_dut_small (.clk, .reset, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .pready(), .prdata(prdata_s), .pslverr(), .high_pin_in,
      .high_pin_out(), .high_pin_oe(), .low_pin_in, .low_pin_out(), .low_pin_oe(), .upper_addr,
      .muxed_bus_out, .muxed_bus_oe, .muxed_bus_in());
   ebp_bus_model i_bus (.clk, .reset, .bus_drive, .ext_high, .ext_low, .high_pin_out,
      .high_pin_oe, .low_pin_out, .low_pin_oe, .high_pin_in, .low_pin_in, .upper_addr,
      .muxed_bus_out, .muxed_bus_oe);
   // ==========================================
   // clock and hang guard
   initial begin
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         close_out;
      end
   end
   task close_out;
      if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // ==========================================
   // apb master: hold until ready seen high
   task apb(input logic w, input logic [31:0] idx, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= idx << 2;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      rd_s = prdata_s;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [31:0] idx, input logic [31:0] d, input logic [3:0] s);
      apb(1'b1, idx, d, s);
   endtask
   task rdc(input logic [31:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0000_0000, 4'h0);
      chk(rd, exp);
   endtask
   // ==========================================
   // scenarios
   task t_reset_state;
      @(negedge clk);
      chk({high_pin_oe, low_pin_oe}, 32'h0000_0000);
      rdc(IDX_LOW_DIR, 32'h0000_ffff);
      rdc(IDX_HIGH_DIR, 32'h0000_00ff);
      rdc(IDX_HIGH_FS, 32'h0000_0000);
      rdc(IDX_LOW_FS, 32'h0000_0000);
   endtask
   task t_high_port;
      @(posedge clk);
      ext_high <= 8'ha5;
      rdc(IDX_HIGH_DATA, 32'h0000_00a5);
      wr(IDX_HIGH_DATA, 32'h0000_003c, 4'h1);
      @(negedge clk);
      chk(high_pin_oe, 32'h0000_0000);
      wr(IDX_HIGH_DIR, 32'h0000_00f0, 4'h1);
      @(negedge clk);
      chk({high_pin_oe, high_pin_out & high_pin_oe}, 32'h0000_0f0c);
      wr(IDX_HIGH_DATA, 32'h0000_0033, 4'h1);
      @(negedge clk);
      chk(high_pin_out & high_pin_oe, 32'h0000_0003);
      rdc(IDX_HIGH_DATA, 32'h0000_00a3);
   endtask
   task t_low_port;
      wr(IDX_LOW_DATA, 32'h0000_1234, 4'h3);
      wr(IDX_LOW_DIR, 32'h0000_ff00, 4'h3);
      @(negedge clk);
      chk({low_pin_oe, low_pin_out & low_pin_oe}, 32'h00ff_0034);
      wr(IDX_LOW_DATA_UPPER, 32'h0000_0056, 4'h1);
      wr(IDX_LOW_DIR_UPPER, 32'h0000_0000, 4'h1);
      @(negedge clk);
      chk({low_pin_oe, low_pin_out}, 32'hffff_5634);
      wr(IDX_LOW_DATA, 32'h0000_ffab, 4'h1);
      rdc(IDX_LOW_DATA, 32'h0000_56ab);
      rdc(IDX_LOW_DATA_UPPER, 32'h0000_0056);
      @(posedge clk);
      ext_low <= 16'h9900;
      wr(IDX_LOW_DIR_UPPER, 32'h0000_00ff, 4'h1);
      repeat (3) @(posedge clk);
      rdc(IDX_LOW_DATA, 32'h0000_99ab);
      wr(IDX_LOW_DATA, 32'h0000_0000, 4'h3);
      @(negedge clk);
      chk({low_pin_oe, low_pin_out & low_pin_oe}, 32'h00ff_0000);
   endtask
   // selects only after the bus side is settled
   task t_control;
      wr(IDX_HIGH_FS, 32'h0000_00ff, 4'h1);
      rdc(IDX_HIGH_FS, 32'h0000_00ff);
      chk(rd_s, 32'h0000_003f);
      @(negedge clk);
      chk({high_pin_oe, high_pin_out}, {8'hff, upper_addr - 8'h01});
      @(posedge clk);
      bus_drive <= 1'b1;
      wr(IDX_LOW_FS, 32'h0000_ffff, 4'h3);
      @(negedge clk);
      chk({low_pin_oe, low_pin_out}, {16'hffff, muxed_bus_out - 16'h0001});
      @(posedge clk);
      bus_drive <= 1'b0;
      // one edge for the enable to drop, three for the pins to reach the bus
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk({low_pin_oe, muxed_bus_in}, 32'h0000_9900);
      wr(IDX_LOW_FS_UPPER, 32'h0000_0000, 4'h1);
      wr(IDX_LOW_FS, 32'h0000_0001, 4'h1);
      rdc(IDX_LOW_FS, 32'h0000_0001);
      wr(IDX_HIGH_FS, 32'h0000_0000, 4'h1);
      @(negedge clk);
      chk({high_pin_oe, high_pin_out & 8'h0f}, 32'h0000_0f03);
   endtask
   task t_refused;
      apb(1'b0, 32'h0000_0040, 32'h0000_0000, 4'h0);
      chk(er, 32'h0000_0001);
      wr(IDX_HIGH_DATA, 32'h0000_00ff, 4'h0);
      chk(er, 32'h0000_0001);
      wr(IDX_LOW_DATA, 32'h0000_ffff, 4'h2);
      chk(er, 32'h0000_0001);
      rdc(IDX_LOW_DATA, 32'h0000_9900);
      rdc(IDX_HIGH_DATA, 32'h0000_00a3);
   endtask
   // ==========================================
   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      t_reset_state;
      t_high_port;
      t_low_port;
      t_control;
      t_refused;
      close_out;
   end
endmodule

// ==== verilog/ebp_pkg.sv ====
// Purpose : shared constants for the external bus port pin block
// Assumes : apb register slave, 32-bit data, one word per register
// Notes   : printed offsets are register indices, byte address is index * 4
package ebp_pkg;

   // ==========================================================
   // widths
   localparam int HIGH_WIDTH = 8;   // high port pins, largest variant
   localparam int LOW_WIDTH  = 16;  // low port pins, every variant
   localparam int DEC_BITS   = 12;  // index bits compared by the decoder

   // ==========================================================
   // register indices (byte address = index * 4)
   localparam logic [31:0] IDX_LOW_DATA       = 32'hffff_f004; // whole + lower byte
   localparam logic [31:0] IDX_LOW_DATA_UPPER = 32'hffff_f005; // upper byte alias
   localparam logic [31:0] IDX_HIGH_DATA      = 32'hffff_f006;
   localparam logic [31:0] IDX_LOW_DIR        = 32'hffff_f024; // whole + lower byte
   localparam logic [31:0] IDX_LOW_DIR_UPPER  = 32'hffff_f025;
   localparam logic [31:0] IDX_HIGH_DIR       = 32'hffff_f026;
   localparam logic [31:0] IDX_LOW_FS         = 32'hffff_f044; // whole + lower byte
   localparam logic [31:0] IDX_LOW_FS_UPPER   = 32'hffff_f045;
   localparam logic [31:0] IDX_HIGH_FS        = 32'hffff_f046;

   // ==========================================================
   // reset values
   localparam logic [15:0] DATA_RESET = 16'h0000; // latch content is don't-care
   localparam logic [15:0] DIR_RESET  = 16'hffff; // all pins start as inputs
   localparam logic [15:0] FS_RESET   = 16'h0000; // all pins start as port

   // ==========================================================
   // implemented function select bits of the high port
   localparam logic [7:0] HIGH_FS_MASK_FULL  = 8'hff; // eight-pin variant
   localparam logic [7:0] HIGH_FS_MASK_SMALL = 8'h3f; // six-pin variant

   // ==========================================================
   // byte strobe patterns
   localparam logic [1:0] STRB_HALF = 2'b11; // halfword access
   localparam logic [1:0] STRB_LOW  = 2'b01; // lower byte access

endpackage

// ==== verilog/ebp_port_bank.sv ====
// Purpose : one port: data latch, direction, function select, pin drive
// Assumes : write enables are single-cycle, pin levels already synchronised
// Notes   : wdata bits sit at register bit positions; we[1] serves bits 15:8
`timescale 1ns/1ps
module ebp_port_bank import ebp_pkg::*; #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,        // system clock
   input  wire logic             reset,      // sync reset, high
   input  wire logic [1:0]       data_we,    // latch byte write enables
   input  wire logic [1:0]       dir_we,     // direction byte write enables
   input  wire logic [1:0]       fs_we,      // function select byte write enables
   input  wire logic [15:0]      wdata,      // write data, register aligned
   input  wire logic [WIDTH-1:0] fs_mask,    // implemented select bits
   input  wire logic [WIDTH-1:0] pin_sync,   // synchronised pin levels
   input  wire logic [WIDTH-1:0] alt_out,    // bus controller drive value
   input  wire logic [WIDTH-1:0] alt_oe,     // bus controller drive enable
   output logic      [WIDTH-1:0] read_view,  // value software reads
   output logic      [WIDTH-1:0] dir_view,   // direction register
   output logic      [WIDTH-1:0] fs_view,    // function select register
   output logic      [WIDTH-1:0] pin_out,    // pin output level
   output logic      [WIDTH-1:0] pin_oe      // pin drive enable
);

   // ==========================================================
   // storage
   logic [WIDTH-1:0] latch_reg;  // data latch
   logic [WIDTH-1:0] dir_reg;    // 1 = input, 0 = output
   logic [WIDTH-1:0] fs_reg;     // 1 = bus function
   logic [WIDTH-1:0] latch_next; // latch after this cycle's write
   logic [WIDTH-1:0] dir_next;   // direction after this cycle's write
   logic [WIDTH-1:0] fs_next;    // select after this cycle's write

   // ==========================================================
   // per-pin logic
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      localparam int B = i / 8; // byte lane of this bit

      // next values, so the pin follows a write on the same edge
      assign latch_next[i] = data_we[B] ? wdata[i] : latch_reg[i];           // [RQ1]
      assign dir_next[i]   = dir_we[B] ? wdata[i] : dir_reg[i];              // [RQ4]
      assign fs_next[i]    = fs_we[B] ? (wdata[i] & fs_mask[i]) : fs_reg[i]; // [RQ5]

      // register state, latch written regardless of direction
      always_ff @(posedge clk) begin
         if (reset) begin
            latch_reg[i] <= DATA_RESET[i];
            dir_reg[i]   <= DIR_RESET[i];  // [RQ16]
            fs_reg[i]    <= FS_RESET[i];   // [RQ5]
         end else begin
            latch_reg[i] <= latch_next[i]; // [RQ2] [RQ10]
            dir_reg[i]   <= dir_next[i];
            fs_reg[i]    <= fs_next[i];    // [RQ6] [RQ7]
         end
      end

      // pin drive: bus controller wins in control mode, else latch/direction
      always_ff @(posedge clk) begin
         if (reset) begin
            pin_out[i] <= 1'b0;
            pin_oe[i]  <= 1'b0;
         end else if (fs_next[i]) begin
            pin_out[i] <= alt_out[i];      // [RQ17] [RQ14]
            pin_oe[i]  <= alt_oe[i];       // [RQ17]
         end else begin
            pin_out[i] <= latch_next[i];   // [RQ3] [RQ11]
            pin_oe[i]  <= ~dir_next[i];    // [RQ16] [RQ2]
         end
      end

      // input mode reads the pin, output mode reads the latch
      assign read_view[i] = dir_reg[i] ? pin_sync[i] : latch_reg[i]; // [RQ2] [RQ3] [RQ10] [RQ11]
   end

   assign dir_view = dir_reg;
   assign fs_view  = fs_reg;

endmodule

// ==== verilog/ebp_port_pins.sv ====
// Purpose : high and low general-purpose ports sharing pins with the external bus
// Assumes : apb slave on the system clock, bus controller on the same clock
// Notes   : pin inputs pass two flops; every output is a flop
//
// Summary of operation
// [RQ1] eight-bit high data latch, read and write
// [RQ2] high input pin: read pin, write latch only
// [RQ3] high output pin: read latch, write drives pin
// [RQ4] eight-bit high direction register, byte access
// [RQ5] six-pin variant: select resets zero, bits 7:6 zero
// [RQ6] eight-pin variant: all select bits drive addresses
// [RQ7] sixteen low pins, each bit controlled alone
// [RQ8] low data halfword whole, byte aliases allowed
// [RQ9] software reaches upper bits via upper alias
// [RQ10] low input pin: read pin, write latch only
// [RQ11] low output pin: read latch, drive at once
// [RQ12] low direction halfword whole, byte aliases allowed
// [RQ13] low select halfword whole, byte aliases allowed
// [RQ14] low control mode carries muxed bus line n
// [RQ15] software minds bus behaviour before selecting control
// [RQ16] direction 0 output, 1 input, resets ones
// [RQ17] control mode: bus controller owns drive and enable
`timescale 1ns/1ps
module ebp_port_pins import ebp_pkg::*; #(
   parameter bit SMALL_HIGH_PORT = 1'b0  // 1 = six-pin high port variant
) (
   input  wire logic        clk,            // system clock, 200 MHz
   input  wire logic        reset,          // sync reset, high
   input  wire logic        psel,           // apb select
   input  wire logic        penable,        // apb access phase
   input  wire logic        pwrite,         // apb write
   input  wire logic [31:0] paddr,          // apb byte address
   input  wire logic [31:0] pwdata,         // apb write data
   input  wire logic [3:0]  pstrb,          // apb byte strobes
   output logic             pready,         // apb ready
   output logic      [31:0] prdata,         // apb read data
   output logic             pslverr,        // apb error
   input  wire logic [7:0]  high_pin_in,    // high port pin levels
   output logic      [7:0]  high_pin_out,   // high port pin drive
   output logic      [7:0]  high_pin_oe,    // high port drive enable
   input  wire logic [15:0] low_pin_in,     // low port pin levels
   output logic      [15:0] low_pin_out,    // low port pin drive
   output logic      [15:0] low_pin_oe,     // low port drive enable
   input  wire logic [7:0]  upper_addr,     // bus address lines 16 up
   input  wire logic [15:0] muxed_bus_out,  // bus address/data drive
   input  wire logic [15:0] muxed_bus_oe,   // bus address/data enable
   output logic      [15:0] muxed_bus_in    // synchronised low pins to bus
);

   // ==========================================================
   // pin synchronisers
   logic [7:0]  high_sync1_reg;  // first stage, read only by second
   logic [7:0]  high_sync2_reg;  // stable high pin levels
   logic [15:0] low_sync1_reg;   // first stage, read only by second
   logic [15:0] low_sync2_reg;   // stable low pin levels

   // pins are asynchronous to clk, so two flops before any use
   always_ff @(posedge clk) begin
      if (reset) begin
         high_sync1_reg <= 8'h00;
         high_sync2_reg <= 8'h00;
         low_sync1_reg  <= 16'h0000;
         low_sync2_reg  <= 16'h0000;
      end else begin
         high_sync1_reg <= high_pin_in;
         high_sync2_reg <= high_sync1_reg;
         low_sync1_reg  <= low_pin_in;
         low_sync2_reg  <= low_sync1_reg;
      end
   end

   // low pins handed to the bus controller as registered levels
   always_ff @(posedge clk) begin
      if (reset) begin
         muxed_bus_in <= 16'h0000;
      end else begin
         muxed_bus_in <= low_sync2_reg; // [RQ14]
      end
   end

   // ==========================================================
   // apb phase tracking
   logic                  ready_reg;  // answer pending in this access cycle
   logic                  first_acc;  // first access-phase cycle
   logic                  commit;     // edge at which the transfer ends
   logic [DEC_BITS-1:0]   idx;        // register index from the address

   // one wait state: lets read data and error come from flops
   assign first_acc = psel & penable & ~ready_reg;
   assign commit    = psel & penable & ready_reg;
   assign idx       = paddr[DEC_BITS+1:2];

   always_ff @(posedge clk) begin
      if (reset) begin
         ready_reg <= 1'b0;
      end else begin
         ready_reg <= first_acc;
      end
   end

   // ==========================================================
   // address decode
   logic hit_ld, hit_ldu, hit_hd;    // data registers
   logic hit_lr, hit_lru, hit_hr;    // direction registers
   logic hit_lf, hit_lfu, hit_hf;    // function select registers
   logic base_hit;                   // any low-port whole register
   logic alias_hit;                  // any byte-wide register
   logic strb_half;                  // halfword access on a base
   logic strb_low;                   // lower byte access on a base
   logic legal;                      // access allowed

   always_comb begin
      hit_ld    = (idx == IDX_LOW_DATA[DEC_BITS-1:0]);
      hit_ldu   = (idx == IDX_LOW_DATA_UPPER[DEC_BITS-1:0]);
      hit_hd    = (idx == IDX_HIGH_DATA[DEC_BITS-1:0]);
      hit_lr    = (idx == IDX_LOW_DIR[DEC_BITS-1:0]);
      hit_lru   = (idx == IDX_LOW_DIR_UPPER[DEC_BITS-1:0]);
      hit_hr    = (idx == IDX_HIGH_DIR[DEC_BITS-1:0]);
      hit_lf    = (idx == IDX_LOW_FS[DEC_BITS-1:0]);
      hit_lfu   = (idx == IDX_LOW_FS_UPPER[DEC_BITS-1:0]);
      hit_hf    = (idx == IDX_HIGH_FS[DEC_BITS-1:0]);
      base_hit  = hit_ld | hit_lr | hit_lf;
      alias_hit = hit_ldu | hit_lru | hit_lfu | hit_hd | hit_hr | hit_hf;
      strb_half = (pstrb[1:0] == STRB_HALF);
      strb_low  = (pstrb[1:0] == STRB_LOW);
      // base accepts the whole halfword or its lower byte; aliases take lane 0
      if (!pwrite) begin
         legal = base_hit | alias_hit;                              // [RQ8]
      end else if (base_hit) begin
         legal = strb_half | strb_low;                              // [RQ8] [RQ12] [RQ13]
      end else begin
         legal = alias_hit & pstrb[0];                              // [RQ9]
      end
   end

   // ==========================================================
   // write enables per byte lane
   logic       wr;                 // committed legal write
   logic [1:0] ld_we, lr_we, lf_we; // low port byte enables
   logic [1:0] hd_we, hr_we, hf_we; // high port enables, lane 0 only
   logic [15:0] low_wdata;          // low port data, lane aligned
   logic [15:0] high_wdata;         // high port data

   always_comb begin
      wr    = commit & pwrite & legal;
      // upper alias lands in bits 15:8, base in 7:0 or 15:0
      ld_we = {wr & ((hit_ld & strb_half) | hit_ldu), wr & hit_ld}; // [RQ8] [RQ9]
      lr_we = {wr & ((hit_lr & strb_half) | hit_lru), wr & hit_lr}; // [RQ12]
      lf_we = {wr & ((hit_lf & strb_half) | hit_lfu), wr & hit_lf}; // [RQ13]
      hd_we = {1'b0, wr & hit_hd};                                  // [RQ1]
      hr_we = {1'b0, wr & hit_hr};                                  // [RQ4]
      hf_we = {1'b0, wr & hit_hf};                                  // [RQ5] [RQ6]
      if (hit_ldu | hit_lru | hit_lfu) begin
         low_wdata = {pwdata[7:0], pwdata[7:0]};
      end else begin
         low_wdata = pwdata[15:0];
      end
      high_wdata = {8'h00, pwdata[7:0]};
   end

   // ==========================================================
   // port banks
   logic [7:0]  high_read, high_dir, high_fs;   // high port views
   logic [15:0] low_read, low_dir, low_fs;      // low port views
   logic [7:0]  high_mask;                      // implemented select bits

   // the small variant cannot set select bits 7 and 6
   assign high_mask = SMALL_HIGH_PORT ? HIGH_FS_MASK_SMALL : HIGH_FS_MASK_FULL; // [RQ5] [RQ6]

   ebp_port_bank #(
      .WIDTH     (HIGH_WIDTH)
   ) u_high (
      .clk       (clk),
      .reset     (reset),
      .data_we   (hd_we),
      .dir_we    (hr_we),
      .fs_we     (hf_we),
      .wdata     (high_wdata),
      .fs_mask   (high_mask),
      .pin_sync  (high_sync2_reg),
      .alt_out   (upper_addr),     // address lines 16 plus bit index
      .alt_oe    (8'hff),          // address lines are output only
      .read_view (high_read),
      .dir_view  (high_dir),
      .fs_view   (high_fs),
      .pin_out   (high_pin_out),
      .pin_oe    (high_pin_oe)
   );

   ebp_port_bank #(
      .WIDTH     (LOW_WIDTH)
   ) u_low (
      .clk       (clk),
      .reset     (reset),
      .data_we   (ld_we),
      .dir_we    (lr_we),
      .fs_we     (lf_we),
      .wdata     (low_wdata),
      .fs_mask   (16'hffff),       // all sixteen select bits exist
      .pin_sync  (low_sync2_reg),
      .alt_out   (muxed_bus_out),  // muxed line n on pin n
      .alt_oe    (muxed_bus_oe),   // bus turns the lines around itself
      .read_view (low_read),
      .dir_view  (low_dir),
      .fs_view   (low_fs),
      .pin_out   (low_pin_out),
      .pin_oe    (low_pin_oe)
   );

   // ==========================================================
   // read mux
   logic [31:0] rd_mux; // read word for the decoded register

   // narrower registers sit low, unused bits read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ld) begin
         rd_mux[15:0] = low_read;          // [RQ8] [RQ10] [RQ11]
      end else if (hit_ldu) begin
         rd_mux[7:0] = low_read[15:8];     // [RQ9]
      end else if (hit_hd) begin
         rd_mux[7:0] = high_read;          // [RQ2] [RQ3]
      end else if (hit_lr) begin
         rd_mux[15:0] = low_dir;           // [RQ12]
      end else if (hit_lru) begin
         rd_mux[7:0] = low_dir[15:8];
      end else if (hit_hr) begin
         rd_mux[7:0] = high_dir;           // [RQ4]
      end else if (hit_lf) begin
         rd_mux[15:0] = low_fs;            // [RQ13]
      end else if (hit_lfu) begin
         rd_mux[7:0] = low_fs[15:8];
      end else if (hit_hf) begin
         rd_mux[7:0] = high_fs;            // [RQ5]
      end
   end

   // ==========================================================
   // apb answer flops
   // answer is captured in the first access cycle and shown in the second
   always_ff @(posedge clk) begin
      if (reset) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (first_acc) begin
         pready  <= 1'b1;
         prdata  <= (!pwrite && legal) ? rd_mux : 32'h0000_0000;
         pslverr <= ~legal;
      end else begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

   // note: a read samples the pin one cycle before pready rises;
   // the level seen is two to three cycles old because of the synchroniser

endmodule
